/* core/watchdog_cause_flag_osc_tick.sv */
module watchdog_cause_flag_osc_tick #(
   parameter int DIV = watchdog_cause_flag_pkg::OSC_DIV
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Oscillator tick
   output logic      tick_o
);

   localparam int CNT_W = (DIV > 1) ? $clog2(DIV) : 1;

   logic [CNT_W-1:0] div_cnt;

   if (DIV < 1) begin
      $error("DIV must be at least one");
   end

   // The watchdog time base is one tick per oscillator period; with DIV of one that is every system clock cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_cnt <= '0;
         tick_o  <= 1'b0;
      end else if (div_cnt == CNT_W'(DIV - 1)) begin
         div_cnt <= '0;
         tick_o  <= 1'b1;
      end else begin
         div_cnt <= div_cnt + CNT_W'(1);
         tick_o  <= 1'b0;
      end
   end

endmodule

/* core/watchdog_cause_flag_pkg.sv */
package watchdog_cause_flag_pkg;

   // Register byte offsets on the Wishbone slave.
   localparam logic [3:0] ADR_CAUSE = 4'h0;
   localparam logic [3:0] ADR_CTRL  = 4'h4;

   // Bit positions in the reset cause register.
   localparam int CAUSE_POR_BIT = 0;
   localparam int CAUSE_EXT_BIT = 1;
   localparam int CAUSE_WDT_BIT = 3;

   // Control register reset value; every bit clear, reset enable included.
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Oscillator and clock rates.
   localparam int CLK_HZ = 10000000;
   localparam int OSC_HZ = 128000;
   localparam int OSC_DIV = CLK_HZ / OSC_HZ;

   // Time-out range in milliseconds and oscillator cycles.
   localparam int TIMEOUT_MIN_MS     = 16;
   localparam int TIMEOUT_MAX_MS     = 8000;
   localparam int TIMEOUT_MIN_CYCLES = 2048;
   localparam logic [3:0] PRESCALE_MAX_CODE = 4'h9;
   localparam int COUNT_W = 20;

   // Length of the protected change window in system clock cycles.
   localparam logic [2:0] CHANGE_WINDOW = 3'h4;

   typedef struct packed {
      logic       irq_flag;
      logic       irq_en;
      logic       wdp3;
      logic       chg_en;
      logic       rst_en;
      logic [2:0] wdp_lo;
   } watchdog_cause_flag_ctrl_s;

   typedef struct packed {
      logic [1:0] reserved_hi;
      logic       usb_flag;
      logic       jtag_flag;
      logic       wdt_flag;
      logic       bod_flag;
      logic       ext_flag;
      logic       por_flag;
   } watchdog_cause_flag_cause_s;

   typedef enum logic [1:0] {
      WATCHDOG_CAUSE_FLAG_STOPPED,
      WATCHDOG_CAUSE_FLAG_IRQ_ONLY,
      WATCHDOG_CAUSE_FLAG_RESET_ONLY,
      WATCHDOG_CAUSE_FLAG_IRQ_THEN_RESET
   } watchdog_cause_flag_mode_e;

endpackage

/* core/watchdog_cause_flag_top.sv */
// Notes on behaviour
// (R1) External reset sets flag; power-on or zero-write clears
// (R2) Power-on sets flag; only zero-write clears it
// (R3) Software reads then clears cause register early
// (R4) Counter advances on dedicated 128 kHz ticks
// (R5) Time-out selectable from 16 ms to 8 s
// (R6) Restart clears counter; expiry gives interrupt or reset
// (R7) Interrupt mode raises wake-capable interrupt on expiry
// (R8) Reset mode issues system reset on expiry
// (R9) Combined mode: interrupt first, then reset
// (R10) Fuse forces reset enable one, interrupt enable zero
// (R11) Clearing reset enable or prescaler needs sequence
// (R12) Opening write sets change and reset enable
// (R13) Second write within four cycles applies values
// (R14) Watchdog stays enabled after its own reset
// (R15) Software clears watchdog flag and enable at start
// (R16) Reset enable reads set while watchdog flag set
// (R17) Change enable clears itself after four cycles
// (R18) Prescaler codes 0..9 select 2048 to 1048576 cycles
// (R19) Combined mode vectoring clears flag and enable
// (R20) Restart clears counter without spurious time-out
// (R21) Unprotected clear or prescaler writes are ignored
//
// Chosen here: the placing of the registers and register access over Wishbone.
module watchdog_cause_flag_top #(
   parameter int ADR_W   = 4,
   parameter int OSC_DIV = watchdog_cause_flag_pkg::OSC_DIV
) (
   // Clock and power-on reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   // Core and reset system
   input  wire logic             ext_reset_i,
   input  wire logic             sys_reset_i,
   input  wire logic             restart_i,
   input  wire logic             irq_vector_ack_i,
   input  wire logic             always_on_fuse_i,
   // Watchdog outputs
   output logic                  timeout_irq_o,
   output logic                  sys_reset_o
);

   localparam int CW = watchdog_cause_flag_pkg::COUNT_W;

   // Both register offsets must be reachable, and the tick divider cannot be zero.
   if (ADR_W < 3) begin
      $error("ADR_W must cover both register words");
   end
   if (OSC_DIV < 1) begin
      $error("OSC_DIV must be at least one");
   end

   // Time-out count for a prescaler code, in oscillator cycles.
   function automatic logic [CW:0] timeout_count(input logic [3:0] code);
      timeout_count = (CW + 1)'(watchdog_cause_flag_pkg::TIMEOUT_MIN_CYCLES) << code; // (R18)
   endfunction

   function automatic logic code_valid(input logic [3:0] code);
      code_valid = (code <= watchdog_cause_flag_pkg::PRESCALE_MAX_CODE); // (R5)
   endfunction

   // Full-width match, so aliases above the two register words never decode.
   function automatic logic adr_hit(input logic [ADR_W-1:0] adr, input logic [3:0] offset);
      adr_hit = (adr == ADR_W'(offset));
   endfunction

   logic                  por_flag;
   logic                  ext_flag;
   logic                  wdt_flag;
   logic                  irq_flag;
   logic                  irq_en;
   logic                  rst_en;
   logic [3:0]            prescale_select;
   logic [2:0]            window_cnt;
   logic [CW-1:0]         count;
   logic                  osc_tick;
   logic                  wb_req;
   logic                  wr_en;
   logic                  wr_cause;
   logic                  wr_ctrl;
   logic [7:0]            wr_byte;
   logic                  rst_en_eff;
   logic                  irq_en_eff;
   logic                  window_open;
   logic                  open_write;
   logic                  change_write;
   logic                  expire;
   logic                  fire_irq;
   logic                  fire_reset;
   logic                  ctrl_clear;
   logic [3:0]            wr_code;
   watchdog_cause_flag_pkg::watchdog_cause_flag_mode_e  mode;
   watchdog_cause_flag_pkg::watchdog_cause_flag_ctrl_s  ctrl_view;
   watchdog_cause_flag_pkg::watchdog_cause_flag_cause_s cause_view;

   // The oscillator is modelled as a divided tick of the system clock; the time-out count stays in ticks.
   watchdog_cause_flag_osc_tick #(
      .DIV    (OSC_DIV)
   ) u_osc (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_o (osc_tick)
   );

   // Bus decode: a request is taken once, in the cycle before ack rises.
   assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_en    = wb_req & wb_we_i & wb_sel_i[0];
   assign wr_cause = wr_en & adr_hit(wb_adr_i, watchdog_cause_flag_pkg::ADR_CAUSE);
   assign wr_ctrl  = wr_en & adr_hit(wb_adr_i, watchdog_cause_flag_pkg::ADR_CTRL);
   assign wr_byte  = wb_dat_i[7:0];
   assign wr_code  = {wr_byte[5], wr_byte[2:0]};

   assign rst_en_eff = rst_en | wdt_flag | always_on_fuse_i; // (R10) (R16)
   assign irq_en_eff = irq_en & ~always_on_fuse_i; // (R10)

   // Interrupt enable is masked by the fuse before decoding, so the fuse always selects reset mode.
   always_comb begin
      unique case ({rst_en_eff, irq_en_eff})
         2'b00:   mode = watchdog_cause_flag_pkg::WATCHDOG_CAUSE_FLAG_STOPPED;
         2'b01:   mode = watchdog_cause_flag_pkg::WATCHDOG_CAUSE_FLAG_IRQ_ONLY;
         2'b10:   mode = watchdog_cause_flag_pkg::WATCHDOG_CAUSE_FLAG_RESET_ONLY;
         2'b11:   mode = watchdog_cause_flag_pkg::WATCHDOG_CAUSE_FLAG_IRQ_THEN_RESET;
      endcase
   end

   assign window_open  = (window_cnt != 3'h0);
   assign open_write   = wr_ctrl & wr_byte[4] & wr_byte[3]; // (R12)
   assign change_write = wr_ctrl & ~wr_byte[4] & window_open; // (R13)

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   // Unmapped words read as zero and ignore writes.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_req && !wb_we_i) begin
         if (adr_hit(wb_adr_i, watchdog_cause_flag_pkg::ADR_CAUSE)) begin
            wb_dat_o <= {24'h00_0000, cause_view};
         end else if (adr_hit(wb_adr_i, watchdog_cause_flag_pkg::ADR_CTRL)) begin
            wb_dat_o <= {24'h00_0000, ctrl_view};
         end else begin
            wb_dat_o <= 32'h0000_0000;
         end
      end
   end

   always_comb begin
      cause_view          = '0;
      cause_view.por_flag = por_flag;
      cause_view.ext_flag = ext_flag;
      cause_view.wdt_flag = wdt_flag;
      ctrl_view.irq_flag  = irq_flag;
      ctrl_view.irq_en    = irq_en_eff;
      ctrl_view.wdp3      = prescale_select[3];
      ctrl_view.chg_en    = window_open; // (R17)
      ctrl_view.rst_en    = rst_en_eff; // (R16)
      ctrl_view.wdp_lo    = prescale_select[2:0];
   end

   // Reset cause flags: hardware set wins over a software zero-write.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         por_flag <= 1'b1; // (R2)
         ext_flag <= 1'b0; // (R1)
         wdt_flag <= 1'b0;
      end else begin
         if (wr_cause && !wr_byte[watchdog_cause_flag_pkg::CAUSE_POR_BIT]) begin
            por_flag <= 1'b0; // (R2)
         end
         if (ext_reset_i) begin
            ext_flag <= 1'b1; // (R1)
         end else if (wr_cause && !wr_byte[watchdog_cause_flag_pkg::CAUSE_EXT_BIT]) begin
            ext_flag <= 1'b0; // (R1)
         end
         if (sys_reset_o) begin
            wdt_flag <= 1'b1; // (R14)
         end else if (wr_cause && !wr_byte[watchdog_cause_flag_pkg::CAUSE_WDT_BIT]) begin
            wdt_flag <= 1'b0;
         end
      end
   end

   // Any system reset, including our own pulse, returns control bits to defaults.
   assign ctrl_clear = sys_reset_i | sys_reset_o;

   // The window counts down from the opening write; the applying write closes it at once,
   // so a second change needs a fresh opening write.
   always_ff @(posedge clk_i) begin
      if (rst_i || ctrl_clear) begin
         window_cnt <= 3'h0;
      end else if (open_write) begin
         window_cnt <= watchdog_cause_flag_pkg::CHANGE_WINDOW; // (R17)
      end else if (change_write) begin
         window_cnt <= 3'h0;
      end else if (window_open) begin
         window_cnt <= window_cnt - 3'h1; // (R17)
      end
   end

   // Reset enable: setting is free, clearing needs the window and a clear watchdog flag.
   // The opening write sets it as well, so the second write must carry the enable wanted.
   always_ff @(posedge clk_i) begin
      if (rst_i || ctrl_clear) begin
         rst_en <= 1'b0;
      end else if (wr_ctrl && wr_byte[3]) begin
         rst_en <= 1'b1;
      end else if (change_write && !wdt_flag) begin
         rst_en <= 1'b0; // (R11) (R13) (R16) (R21)
      end
   end

   // Reserved prescaler codes are refused so the time-out stays defined.
   // The count is not restarted here: a shorter period chosen while the count is already past
   // it lets the counter run on to its wrap, so software should restart before a change.
   always_ff @(posedge clk_i) begin
      if (rst_i || ctrl_clear) begin
         prescale_select <= {watchdog_cause_flag_pkg::CTRL_RESET[5], watchdog_cause_flag_pkg::CTRL_RESET[2:0]};
      end else if (change_write && code_valid(wr_code)) begin
         prescale_select <= wr_code; // (R11) (R13) (R21)
      end
   end

   // A vector clear wins over a same-cycle write, so combined mode cannot re-arm by accident.
   always_ff @(posedge clk_i) begin
      if (rst_i || ctrl_clear) begin
         irq_en <= 1'b0;
      end else if (irq_vector_ack_i && mode == watchdog_cause_flag_pkg::WATCHDOG_CAUSE_FLAG_IRQ_THEN_RESET) begin
         irq_en <= 1'b0; // (R19)
      end else if (wr_ctrl) begin
         irq_en <= wr_byte[6];
      end
   end

   // Time-out counter on oscillator ticks; a restart always wins over expiry.
   // Expiry is matched one below the selected count because the counter clears on that tick,
   // which makes the period exactly the selected number of ticks.
   assign expire = osc_tick & ~restart_i & (mode != watchdog_cause_flag_pkg::WATCHDOG_CAUSE_FLAG_STOPPED)
                   & ((CW + 1)'(count) == timeout_count(prescale_select) - (CW + 1)'(1)); // (R6)

   always_ff @(posedge clk_i) begin
      if (rst_i || ctrl_clear || restart_i) begin
         count <= '0; // (R6) (R20)
      end else if (mode == watchdog_cause_flag_pkg::WATCHDOG_CAUSE_FLAG_STOPPED || expire) begin
         count <= '0;
      end else if (osc_tick) begin
         count <= count + CW'(1); // (R4)
      end
   end

   always_comb begin
      fire_irq   = 1'b0;
      fire_reset = 1'b0;
      if (expire) begin
         unique case (mode)
            watchdog_cause_flag_pkg::WATCHDOG_CAUSE_FLAG_STOPPED: begin
            end
            watchdog_cause_flag_pkg::WATCHDOG_CAUSE_FLAG_IRQ_ONLY: begin
               fire_irq = 1'b1; // (R7)
            end
            watchdog_cause_flag_pkg::WATCHDOG_CAUSE_FLAG_RESET_ONLY: begin
               fire_reset = 1'b1; // (R8) (R10)
            end
            watchdog_cause_flag_pkg::WATCHDOG_CAUSE_FLAG_IRQ_THEN_RESET: begin
               fire_irq   = ~irq_flag; // (R9)
               fire_reset = irq_flag; // (R9)
            end
         endcase
      end
   end

   // Interrupt flag: a new time-out wins over a one-write or a vector clear.
   always_ff @(posedge clk_i) begin
      if (rst_i || ctrl_clear) begin
         irq_flag <= 1'b0;
      end else if (fire_irq) begin
         irq_flag <= 1'b1; // (R7) (R9)
      end else if (irq_vector_ack_i || (wr_ctrl && wr_byte[7])) begin
         irq_flag <= 1'b0; // (R19)
      end
   end

   // One-cycle pulse; the control clear it triggers keeps it from repeating at once.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sys_reset_o <= 1'b0;
      end else begin
         sys_reset_o <= fire_reset; // (R8)
      end
   end

   // Level output; it is not gated by a clock so it can serve as a wake request.
   assign timeout_irq_o = irq_flag & irq_en_eff; // (R7)

endmodule

/* tb/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i;
   logic        rst_i;
   logic        cyc;
   logic        we;
   logic        fuse;
   logic        ack;
   logic        irq;
   logic        sreset;
   logic [2:0]  pl;
   logic [3:0]  adr;
   logic [3:0]  c;
   logic [3:0]  cur;
   logic [31:0] dat;
   logic [31:0] rdo;
   logic [31:0] rdat;
   logic [31:0] seed;
   int          n;
   int          num_errors;
   int          total_checks;

   // Bit 0 restarts, bit 1 acknowledges the vector, bit 2 flags an external reset.
   watchdog_cause_flag_top #(.ADR_W(4), .OSC_DIV(1)) u_watchdog_cause_flag_top (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack),
      .ext_reset_i(pl[2]), .sys_reset_i(1'b0), .restart_i(pl[0]), .irq_vector_ack_i(pl[1]),
      .always_on_fuse_i(fuse), .timeout_irq_o(irq), .sys_reset_o(sreset)
   );

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // Control byte with reset enable set and the given prescaler code.
   function automatic logic [7:0] ctl(input logic [3:0] p);
      return {2'h0, p[3], 2'h1, p[2:0]};
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic wrap_up();
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 20);
      rdat = rdo;
      chk({31'h0, ack}, 32'h1);
      cyc <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(rdat, {24'h0, e});
   endtask

   task automatic pls(input logic [2:0] m);
      @(posedge clk_i);
      pl <= m;
      @(posedge clk_i);
      pl <= 3'h0;
   endtask

   // The wait stops on the first edge that samples the chosen output high.
   task automatic wt(input logic s);
      n = 0;
      while ((s ? sreset : irq) !== 1'b1 && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
   endtask

   initial begin
      #4000000;
      num_errors++;
      wrap_up();
   end

   initial begin
      {rst_i, cyc, we, fuse, pl, adr, dat, seed} = {4'h8, 3'h0, 4'h0, 32'h0, 32'hE};
      num_errors = 0;
      total_checks = 0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(4'h0, 8'h01);
      rd(4'h4, 8'h00);
      rd(4'h8, 8'h00);
      pls(3'h4);
      rd(4'h0, 8'h03);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(4'h0, 8'h01);
      wb(1'b1, 4'h0, 8'h00);
      rd(4'h0, 8'h00);
      $display("cause flags done");
      pls(3'h1);
      wb(1'b1, 4'h4, 8'h08);
      wb(1'b1, 4'h4, 8'h00);
      rd(4'h4, 8'h08);
      wb(1'b1, 4'h4, 8'h18);
      rd(4'h4, 8'h18);
      repeat (6) @(posedge clk_i);
      wb(1'b1, 4'h4, 8'h00);
      rd(4'h4, 8'h08);
      cur = 4'h0;
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         c = (i == 0) ? 4'h9 : (i == 1) ? 4'hF : seed[3:0];
         pls(3'h1);
         wb(1'b1, 4'h4, 8'h18);
         wb(1'b1, 4'h4, ctl(c));
         if (c <= 4'h9)
            cur = c;
         rd(4'h4, ctl(cur));
         wb(1'b1, 4'h4, ctl(seed[7:4]));
         rd(4'h4, ctl(cur));
      end
      wb(1'b1, 4'h4, 8'h18);
      wb(1'b1, 4'h4, 8'h00);
      rd(4'h4, 8'h00);
      $display("protected writes done");
      wb(1'b1, 4'h4, 8'h40);
      pls(3'h1);
      repeat (3) begin
         repeat (1500) @(posedge clk_i);
         pls(3'h1);
      end
      chk({31'h0, irq}, 32'h0);
      wt(1'b0);
      chk({31'h0, n >= 2040 && n <= 2060}, 32'h1);
      pls(3'h2);
      @(posedge clk_i);
      chk({31'h0, irq}, 32'h0);
      rd(4'h4, 8'h40);
      $display("interrupt mode done");
      pls(3'h1);
      wb(1'b1, 4'h4, 8'h48);
      wt(1'b0);
      chk({30'h0, irq, sreset}, 32'h2);
      pls(3'h2);
      rd(4'h4, 8'h08);
      wt(1'b1);
      chk({31'h0, sreset}, 32'h1);
      rd(4'h0, 8'h08);
      rd(4'h4, 8'h08);
      wb(1'b1, 4'h4, 8'h18);
      wb(1'b1, 4'h4, 8'h00);
      rd(4'h4, 8'h08);
      wb(1'b1, 4'h0, 8'h00);
      wb(1'b1, 4'h4, 8'h18);
      wb(1'b1, 4'h4, 8'h00);
      rd(4'h4, 8'h00);
      $display("combined mode done");
      fuse <= 1'b1;
      rd(4'h4, 8'h08);
      wb(1'b1, 4'h4, 8'h40);
      rd(4'h4, 8'h08);
      wb(1'b1, 4'h4, 8'h18);
      wb(1'b1, 4'h4, 8'h00);
      rd(4'h4, 8'h08);
      fuse <= 1'b0;
      $display("fuse done");
      wrap_up();
   end
endmodule

/* tb/watchdog_cause_flag_props.sv */
module watchdog_cause_flag_props #(
   parameter int ADR_W   = 4,
   parameter int OSC_DIV = watchdog_cause_flag_pkg::OSC_DIV
) (
   // Clock and reset
   input wire logic             clk_i,
   input wire logic             rst_i,
   // Wishbone
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0]       wb_sel_i,
   input wire logic [31:0]      wb_dat_i,
   input wire logic [31:0]      wb_dat_o,
   input wire logic             wb_ack_o,
   // Core side
   input wire logic             ext_reset_i,
   input wire logic             sys_reset_i,
   input wire logic             restart_i,
   input wire logic             irq_vector_ack_i,
   input wire logic             always_on_fuse_i,
   input wire logic             timeout_irq_o,
   input wire logic             sys_reset_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence unmapped_s;
      wb_ack_o && !wb_we_i && wb_adr_i != ADR_W'(4'h0) && wb_adr_i != ADR_W'(4'h4);
   endsequence
   ack_next_a: assert property (req_s |=> wb_ack_o)
      else $error("ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack unasked");
   dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper data set");
   unmapped_zero_a: assert property (unmapped_s |-> wb_dat_o == 32'h0)
      else $error("unmapped data");
   fuse_irq_a: assert property (always_on_fuse_i |-> !timeout_irq_o)
      else $error("irq under fuse");
   vec_clear_a: assert property (irq_vector_ack_i && timeout_irq_o |=> !timeout_irq_o)
      else $error("vector kept irq");
   restart_quiet_a: assert property (restart_i |=> !sys_reset_o)
      else $error("reset after restart");
   reset_gap_a: assert property (sys_reset_o |=> !sys_reset_o [*8])
      else $error("reset repeated");
endmodule

bind watchdog_cause_flag_top watchdog_cause_flag_props #(.ADR_W(ADR_W), .OSC_DIV(OSC_DIV)) u_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_reset_i(ext_reset_i),
   .sys_reset_i(sys_reset_i), .restart_i(restart_i), .irq_vector_ack_i(irq_vector_ack_i),
   .always_on_fuse_i(always_on_fuse_i), .timeout_irq_o(timeout_irq_o),
   .sys_reset_o(sys_reset_o)
);
